// File: common/pbs_pkg.sv
/*
  pbs_pkg: shared constants and types of the pipelined burst sram port.
  assumes: nothing beyond a systemverilog compiler.
*/
package pbs_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int PBS_LANE_BITS  = 9;   // eight data bits plus one parity bit
  localparam int PBS_BYTE_BITS  = 8;   // data bits of one lane
  localparam int PBS_LANES      = 4;   // wide variant; narrow variant uses 2
  localparam int PBS_ADDR_W     = 19;  // word address width of the wide variant
  localparam int PBS_FIFO_DEPTH = 16;  // write buffer entries
  localparam int PBS_BURST_W    = 2;   // wrapping burst counter width

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [PBS_BURST_W-1:0] PBS_CNT_RESET   = 2'h0;  // burst counter
  localparam logic                   PBS_DRIVE_RESET = 1'h0;  // bus released
  localparam logic                   PBS_SYNC_RESET  = 1'h0;  // sleep synchroniser

  // ****************************************
  // per-cycle operations
  // ****************************************
  typedef enum logic [2:0] {
    PBS_OP_SLEEP,
    PBS_OP_DESELECT,
    PBS_OP_READ_EXT,
    PBS_OP_WRITE_EXT,
    PBS_OP_READ_NEXT,
    PBS_OP_WRITE_NEXT,
    PBS_OP_READ_CUR,
    PBS_OP_WRITE_CUR
  } pbs_op_e;

endpackage

// File: src/pbs_sram_port.sv
/*
  pbs_sram_port: synchronous control of a pipelined, double-cycle-deselect
  burst sram, with a write buffer fifo between the bus and the array.
  assumes: bus inputs come from logic on i_clock; sleep request is a pin
  and is synchronised; output enable acts on the drivers without a clock.
*/
// Contract
// R1: processor strobe start reads external address
// R2: controller strobe, write inactive: read start
// R3: controller strobe, write active: write start
// R4: writes only after processor or with controller
// R5: no strobe, advance low, read: read next
// R6: no strobe, advance low, write: write next
// R7: advance high, read: hold counter, reread
// R8: advance high, write: hold counter, rewrite
// R9: write qualifier active per global/byte enables
// R10: all enables high means read
// R11: byte write writes exactly enabled lanes
// R12: output enable asynchronous, masked during writes
// R13: controller raises output enable before writes
// R14: output enable ignored once write started
// R15: reads tristate when disabled or deselected
// R16: selected read with enable drives all bits
// R17: drive set by operation and enable
// R18: bad selects with strobe cause deselect; the code ignores a processor strobe while pipelined select is high
// R19: sleep ignores inputs, keeps bus tristated
// R20: sleep entry and exit take two cycles
// R21: two-bit wrapping counter, linear or interleaved
// R22: deselect releases bus one cycle later
// R23: processor write captures data second edge
`timescale 1ns/1ns

// ****************************************
// write buffer fifo
// ****************************************
module pbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = pbs_pkg::PBS_FIFO_DEPTH
) (
  // clock and control
  input  wire logic             i_clock,
  input  wire logic             i_rstn,
  input  wire logic             i_clk_en,
  // filling side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output      logic             o_in_ready,
  // draining side
  output      logic             o_out_valid,
  output      logic [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  import pbs_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store [DEPTH];  // entry storage
  logic [PTR_W-1:0] wr_ptr;         // next slot to fill
  logic [PTR_W-1:0] rd_ptr;         // oldest slot
  logic [CNT_W-1:0] count;          // entries held
  logic             full;           // registered full flag
  logic             empty;          // registered empty flag
  logic             push;           // accepted write
  logic             pop;            // accepted read

  assign push        = i_in_valid && !full;
  assign pop         = i_out_ready && !empty;
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = store[rd_ptr];

  // storage write
  always_ff @(posedge i_clock) begin
    if (i_clk_en && push) begin
      store[wr_ptr] <= i_in_data;
    end
  end

  // pointers and flags
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      full   <= 1'b0;
      empty  <= 1'b1;
    end else if (i_clk_en) begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(rd_ptr + 1'b1);
      end
      // simultaneous push and pop leaves the count alone
      if (push && !pop) begin
        count <= CNT_W'(count + 1'b1);
        full  <= (count == CNT_W'(DEPTH - 1));
        empty <= 1'b0;
      end else if (pop && !push) begin
        count <= CNT_W'(count - 1'b1);
        full  <= 1'b0;
        empty <= (count == CNT_W'(1));
      end
    end
  end

endmodule // pbs_fifo

// ****************************************
// sram port top
// ****************************************
module pbs_sram_port #(
  parameter int LANES      = pbs_pkg::PBS_LANES,
  parameter int LANE_BITS  = pbs_pkg::PBS_LANE_BITS,
  parameter int ADDR_W     = pbs_pkg::PBS_ADDR_W,
  parameter int FIFO_DEPTH = pbs_pkg::PBS_FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic                    i_clock,
  input  wire logic                    i_rstn,
  input  wire logic                    i_clk_en,
  // selects and strobes
  input  wire logic                    i_pipelined_select_low_n,
  input  wire logic                    i_depth_select_high,
  input  wire logic                    i_depth_select_low_n,
  input  wire logic                    i_processor_addr_strobe_n,
  input  wire logic                    i_controller_addr_strobe_n,
  input  wire logic                    i_burst_advance_n,
  input  wire logic                    i_burst_interleave,
  input  wire logic                    i_sleep_request,
  input  wire logic [ADDR_W-1:0]       i_addr,
  // write qualifiers
  input  wire logic                    i_global_write_n,
  input  wire logic                    i_byte_write_enable_n,
  input  wire logic [LANES-1:0]        i_byte_lane_write_n,
  // data bus, split into in, out, enable
  input  wire logic                    i_output_enable_n,
  input  wire logic [LANES*8-1:0]      i_data_io,
  input  wire logic [LANES-1:0]        i_parity_io,
  output      logic [LANES*8-1:0]      o_data_io,
  output      logic [LANES-1:0]        o_parity_io,
  output      logic                    o_data_oe,
  // write buffer back-pressure
  output      logic                    o_wbuf_ready
);
  import pbs_pkg::*;

  localparam int WORD_W  = LANES * LANE_BITS;
  localparam int ENTRY_W = ADDR_W + LANES + WORD_W;

  logic [WORD_W-1:0]      mem [2**ADDR_W];   // array, flip-flops
  logic                   slp_meta;          // sleep sync, first stage
  logic                   slp_sync;          // sleep sync, second stage
  logic                   active;            // a burst is open
  logic [ADDR_W-1:0]      base;              // burst start address
  logic [PBS_BURST_W-1:0] cnt;               // burst position
  logic                   rd_pend;           // read registered last edge
  logic [ADDR_W-1:0]      rd_addr;           // address of that read
  logic                   drive;             // output stage owns the bus
  logic [WORD_W-1:0]      out_word;          // output register
  pbs_op_e                next_op;           // operation of this edge
  logic                   write_q;           // combined write qualifier
  logic [LANES-1:0]       lane_en;           // lanes to write
  logic [PBS_BURST_W-1:0] cnt_next;          // counter after advance
  logic [ADDR_W-1:0]      acc_addr;          // address used this edge
  logic                   is_read;           // read of an open burst
  logic                   is_write;          // write of an open burst
  logic [WORD_W-1:0]      in_word;           // bus data, lane packed
  logic [ENTRY_W-1:0]     push_entry;        // buffered write
  logic                   wb_valid;          // buffer head present
  logic [ENTRY_W-1:0]     wb_entry;          // buffer head
  logic                   wb_ready;          // buffer accepts

  // ****************************************
  // write qualifier and lane decode
  // ****************************************
  always_comb begin
    write_q = !i_global_write_n ||
              (!i_byte_write_enable_n && !(&i_byte_lane_write_n));  // R9 R10
    if (!i_global_write_n) begin
      lane_en = '1;                                  // global write, all lanes
    end else if (!i_byte_write_enable_n) begin
      lane_en = ~i_byte_lane_write_n;                // R11
    end else begin
      lane_en = '0;                                  // read
    end
  end

  // ****************************************
  // operation decode
  // ****************************************
  always_comb begin
    if (slp_sync) begin
      next_op = PBS_OP_SLEEP;                        // R19
    end else if (!i_processor_addr_strobe_n && !i_pipelined_select_low_n) begin
      // write controls ignored on a processor start
      next_op = (i_depth_select_high && !i_depth_select_low_n) ?
                PBS_OP_READ_EXT : PBS_OP_DESELECT;   // R1 R4 R18
    end else if (!i_controller_addr_strobe_n) begin
      if (i_pipelined_select_low_n || !i_depth_select_high || i_depth_select_low_n) begin
        next_op = PBS_OP_DESELECT;                   // R18
      end else if (write_q) begin
        next_op = PBS_OP_WRITE_EXT;                  // R3 R4
      end else begin
        next_op = PBS_OP_READ_EXT;                   // R2
      end
    end else if (!i_burst_advance_n) begin
      next_op = write_q ? PBS_OP_WRITE_NEXT : PBS_OP_READ_NEXT;  // R5 R6
    end else begin
      next_op = write_q ? PBS_OP_WRITE_CUR : PBS_OP_READ_CUR;    // R7 R8 R23
    end
  end

  // ****************************************
  // burst address generation
  // ****************************************
  function automatic logic [PBS_BURST_W-1:0] burst_seq(
    input logic [PBS_BURST_W-1:0] start,
    input logic [PBS_BURST_W-1:0] pos,
    input logic                   interleave
  );
    // interleaved xors, linear adds and wraps
    burst_seq = interleave ? (start ^ pos) : PBS_BURST_W'(start + pos);  // R21
  endfunction

  assign cnt_next = PBS_BURST_W'(cnt + 1'b1);

  // address of the access taken at this edge
  always_comb begin
    unique case (next_op)
      PBS_OP_READ_EXT, PBS_OP_WRITE_EXT: begin
        acc_addr = i_addr;
      end
      PBS_OP_READ_NEXT, PBS_OP_WRITE_NEXT: begin
        acc_addr = {base[ADDR_W-1:PBS_BURST_W],
                    burst_seq(base[PBS_BURST_W-1:0], cnt_next, i_burst_interleave)};  // R5 R6
      end
      PBS_OP_SLEEP, PBS_OP_DESELECT, PBS_OP_READ_CUR, PBS_OP_WRITE_CUR: begin
        acc_addr = {base[ADDR_W-1:PBS_BURST_W],
                    burst_seq(base[PBS_BURST_W-1:0], cnt, i_burst_interleave)};       // R7 R8
      end
    endcase
  end

  assign is_read  = (next_op == PBS_OP_READ_EXT) ||
                    (active && (next_op == PBS_OP_READ_NEXT || next_op == PBS_OP_READ_CUR));
  assign is_write = (next_op == PBS_OP_WRITE_EXT) ||
                    (active && (next_op == PBS_OP_WRITE_NEXT || next_op == PBS_OP_WRITE_CUR));

  // ****************************************
  // sleep request synchroniser
  // ****************************************
  // two flops give the two-cycle entry and exit
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      slp_meta <= PBS_SYNC_RESET;
      slp_sync <= PBS_SYNC_RESET;
    end else if (i_clk_en) begin
      slp_meta <= i_sleep_request;                   // R20
      slp_sync <= slp_meta;
    end
  end

  // ****************************************
  // burst state
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      active <= 1'b0;
      base   <= '0;
      cnt    <= PBS_CNT_RESET;
    end else if (i_clk_en) begin
      unique case (next_op)
        PBS_OP_READ_EXT, PBS_OP_WRITE_EXT: begin
          active <= 1'b1;                            // start from external address
          base   <= i_addr;
          cnt    <= PBS_CNT_RESET;
        end
        PBS_OP_READ_NEXT, PBS_OP_WRITE_NEXT: begin
          if (active) begin
            cnt <= cnt_next;                         // R21
          end
        end
        PBS_OP_READ_CUR, PBS_OP_WRITE_CUR: begin
          cnt <= cnt;                                // counter held
        end
        PBS_OP_SLEEP, PBS_OP_DESELECT: begin
          active <= 1'b0;                            // R18 R19
        end
      endcase
    end
  end

  // ****************************************
  // read pipeline and output stage
  // ****************************************
  // read address registered at this edge
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      rd_pend <= 1'b0;
      rd_addr <= '0;
    end else if (i_clk_en) begin
      rd_pend <= is_read;
      rd_addr <= acc_addr;
    end
  end

  // data reaches the pins one edge later
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      out_word <= '0;
    end else if (i_clk_en && rd_pend) begin
      out_word <= mem[rd_addr];
    end
  end

  // drive follows the registered read, so a deselect lets go one edge late
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      drive <= PBS_DRIVE_RESET;
    end else if (i_clk_en) begin
      if (is_write || slp_sync) begin
        drive <= 1'b0;                               // R12 R14 R19
      end else begin
        drive <= rd_pend;                            // R15 R22
      end
    end
  end

  // ****************************************
  // pins
  // ****************************************
  // enable is not clocked: the output flop gated by the pin
  assign o_data_oe = drive && !i_output_enable_n;   // R12 R16 R17

  generate
    for (genvar l = 0; l < LANES; l++) begin : g_lane
      assign in_word[l*LANE_BITS +: LANE_BITS] = {i_parity_io[l], i_data_io[l*8 +: 8]};
      assign o_data_io[l*8 +: 8]               = out_word[l*LANE_BITS +: 8];
      assign o_parity_io[l]                    = out_word[l*LANE_BITS + 8];
    end
  endgenerate

  // ****************************************
  // write buffer and array write
  // ****************************************
  assign push_entry   = {acc_addr, lane_en, in_word};
  assign o_wbuf_ready = wb_ready;

  pbs_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wbuf (
    .i_clock     (i_clock),
    .i_rstn      (i_rstn),
    .i_clk_en    (i_clk_en),
    .i_in_valid  (is_write),                         // R3 R6 R8 R23
    .i_in_data   (push_entry),
    .o_in_ready  (wb_ready),
    .o_out_valid (wb_valid),
    .o_out_data  (wb_entry),
    .i_out_ready (!rd_pend)
  );

  // drain stalls while the array serves a read
  generate
    for (genvar l = 0; l < LANES; l++) begin : g_wr
      always_ff @(posedge i_clock) begin
        if (i_clk_en && wb_valid && !rd_pend && wb_entry[WORD_W + l]) begin
          mem[wb_entry[ENTRY_W-1 -: ADDR_W]][l*LANE_BITS +: LANE_BITS] <=
            wb_entry[l*LANE_BITS +: LANE_BITS];      // R11
        end
      end
    end
  endgenerate

endmodule // pbs_sram_port

// File: tb/pbs_host_model.sv
/*
  pbs_host_model: cache controller side of the sram bus, with the shared wire.
  assumes: one clock; control vector is {proc, ctrl, advance, global, byte} strobes.
*/
`timescale 1ns/1ns
module pbs_host_model (
  // clock and device side
  input  wire logic        i_clock,
  input  wire logic [35:0] i_dev_q,
  input  wire logic        i_dev_oe,
  // strobes, selects, qualifiers
  output logic [4:0]       o_ctl,
  output logic [2:0]       o_sel,
  output logic [3:0]       o_lane_n,
  output logic [5:0]       o_addr,
  output logic             o_oe_n,
  output logic             o_sleep,
  // resolved data and parity wire
  output logic [35:0]      o_bus
);
  logic [35:0] wdat;  // write data of the cycle
  logic        hdrv;  // host drives the wire
  logic [35:0] last;  // previous wire level

  // idle, deselected bus from time zero
  initial begin
    o_ctl = 5'h1F;
    o_sel = 3'h6;
    o_lane_n = 4'hF;
    o_addr = 6'h0;
    o_oe_n = 1'b1;
    o_sleep = 1'b0;
    wdat = 36'h0;
    hdrv = 1'b0;
    last = 36'h0;
  end
  // released wire flips every cycle so no stale value passes
  always_comb begin
    if (i_dev_oe) o_bus = i_dev_q;
    else if (hdrv) o_bus = wdat;
    else o_bus = ~last;
  end
  always_ff @(posedge i_clock) last <= o_bus;

  // one bus cycle, launched at the edge
  task automatic bus(input logic [4:0] c, input logic [2:0] s, input logic [3:0] bw,
                     input logic [5:0] a, input logic [35:0] d, input logic oe_n);
    @(posedge i_clock);
    o_ctl    <= c;
    o_sel    <= s;
    o_lane_n <= bw;
    o_addr   <= a;
    wdat     <= d;
    hdrv     <= !c[1] | !c[0];
    o_oe_n   <= oe_n | ((!c[1] | !c[0]) & !(c[4] & c[3]));
  endtask
  // sleep pin level
  task automatic nap(input logic v);
    @(posedge i_clock);
    o_sleep <= v;
  endtask
endmodule // pbs_host_model

// File: tb/pbs_sram_port_sva.sv
/*
  pbs_sram_port_sva: decode and bus drive checks of the sram port.
  assumes: bound to pbs_sram_port, i_clk_en high except for two edges frozen by the bench.
*/
`timescale 1ns/1ns
module pbs_sram_port_sva #(
  parameter int LANES = 4
) (
  // clock and reset
  input wire logic             i_clock,
  input wire logic             i_rstn,
  // selects, strobes, sleep
  input wire logic             i_pipelined_select_low_n,
  input wire logic             i_depth_select_high,
  input wire logic             i_depth_select_low_n,
  input wire logic             i_processor_addr_strobe_n,
  input wire logic             i_controller_addr_strobe_n,
  input wire logic             i_sleep_request,
  // write qualifiers and drive
  input wire logic             i_global_write_n,
  input wire logic             i_byte_write_enable_n,
  input wire logic [LANES-1:0] i_byte_lane_write_n,
  input wire logic             i_output_enable_n,
  input wire logic             o_data_oe,
  input wire logic             o_wbuf_ready
);
  logic [2:0] slp_hist;  // recent sleep pin samples
  logic       qual;      // combined write qualifier active
  logic       sel_ok;    // all three selects active
  logic       awake;     // sleep pin quiet long enough
  logic       desel;     // deselect decoded this edge

  // sleep pin history, so decode is trusted only well clear of sleep
  always_ff @(posedge i_clock) begin
    if (!i_rstn) slp_hist <= 3'h0;
    else slp_hist <= {slp_hist[1:0], i_sleep_request};
  end
  assign qual   = !i_global_write_n | (!i_byte_write_enable_n & !(&i_byte_lane_write_n));
  assign sel_ok = !i_pipelined_select_low_n & i_depth_select_high & !i_depth_select_low_n;
  assign awake  = !i_sleep_request & !(|slp_hist);
  assign desel  = awake & !sel_ok & ((!i_processor_addr_strobe_n & !i_pipelined_select_low_n)
                  | !i_controller_addr_strobe_n);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  // ****************************************
  // operation sequences
  // ****************************************
  sequence s_proc_read;
    awake & sel_ok & !i_processor_addr_strobe_n;
  endsequence
  sequence s_ctrl_start;
    awake & sel_ok & i_processor_addr_strobe_n & !i_controller_addr_strobe_n;
  endsequence
  sequence s_cont;
    awake & i_processor_addr_strobe_n & i_controller_addr_strobe_n;
  endsequence

  AST_RESET_STATE: assert property ($rose(i_rstn) |-> o_wbuf_ready && !o_data_oe)
    else $error("bad state after reset");
  AST_PROC_READ: assert property (s_proc_read ##1 !qual |-> ##1 (i_output_enable_n || o_data_oe))
    else $error("processor strobe start did not read");
  AST_CTRL_READ: assert property (s_ctrl_start ##0 !qual ##1 !qual |-> ##1 (i_output_enable_n || o_data_oe))
    else $error("controller read not driven");
  AST_CTRL_WRITE: assert property (s_ctrl_start ##0 qual |=> !o_data_oe)
    else $error("bus driven on controller write");
  AST_CONT_READ: assert property ((s_ctrl_start or s_proc_read) ##1 (s_cont ##0 !qual) ##1 !qual
    |-> ##1 (i_output_enable_n || o_data_oe))
    else $error("continued read not driven");
  AST_CONT_WRITE: assert property ((s_ctrl_start or s_proc_read) ##1 (s_cont ##0 qual) |=> !o_data_oe)
    else $error("bus driven on continued write");
  AST_DESELECT: assert property (desel |-> ##2 !o_data_oe)
    else $error("bus still driven after deselect");
  AST_SLEEP_QUIET: assert property (i_sleep_request [*4] |=> !o_data_oe)
    else $error("bus driven in sleep");
  AST_OE_MASK: assert property (i_output_enable_n |-> !o_data_oe)
    else $error("bus driven with output enable high");
endmodule // pbs_sram_port_sva

bind pbs_sram_port pbs_sram_port_sva #(.LANES(LANES)) i_sva (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_pipelined_select_low_n(i_pipelined_select_low_n),
  .i_depth_select_high(i_depth_select_high), .i_depth_select_low_n(i_depth_select_low_n),
  .i_processor_addr_strobe_n(i_processor_addr_strobe_n), .i_sleep_request(i_sleep_request),
  .i_controller_addr_strobe_n(i_controller_addr_strobe_n), .i_global_write_n(i_global_write_n),
  .i_byte_write_enable_n(i_byte_write_enable_n), .i_byte_lane_write_n(i_byte_lane_write_n),
  .i_output_enable_n(i_output_enable_n), .o_data_oe(o_data_oe), .o_wbuf_ready(o_wbuf_ready));

// File: tb/test_pbs_sram_port.sv
/*
  test_pbs_sram_port: self-checking bench of the sram port.
  assumes: host model drives the bus; word address width reduced to 6.
*/
`timescale 1ns/1ns
module test_pbs_sram_port;
  import pbs_pkg::*;
  localparam logic [4:0] C_RD = 5'h17, C_WR = 5'h15, C_BW = 5'h16, C_PS = 5'h0F, C_PSW = 5'h0D;
  localparam logic [4:0] C_NXR = 5'h1B, C_NXW = 5'h19, C_CUR = 5'h1F, C_CUW = 5'h1D;
  localparam logic [2:0] S_OK = 3'h2, S_OFF = 3'h6;
  logic clk = 1'b0;
  logic rstn, mode, oe, rdy, hoe_n, slp, en;
  logic [4:0] ctl;
  logic [2:0] sel;
  logic [3:0] lane_n, par;
  logic [5:0] addr;
  logic [35:0] wire_q;
  logic [31:0] dq;
  logic [35:0] mem [64];  // expected array
  int n_fail, cmp_count;

  always #20 clk = ~clk;
  pbs_host_model i_host (.i_clock(clk), .i_dev_q({par, dq}), .i_dev_oe(oe), .o_ctl(ctl), .o_sel(sel),
    .o_lane_n(lane_n), .o_addr(addr), .o_oe_n(hoe_n), .o_sleep(slp), .o_bus(wire_q));
  pbs_sram_port #(.ADDR_W(6)) i_dut (.i_clock(clk), .i_rstn(rstn), .i_clk_en(en),
    .i_pipelined_select_low_n(sel[2]), .i_depth_select_high(sel[1]), .i_depth_select_low_n(sel[0]),
    .i_processor_addr_strobe_n(ctl[4]), .i_controller_addr_strobe_n(ctl[3]), .i_burst_advance_n(ctl[2]),
    .i_burst_interleave(mode), .i_sleep_request(slp), .i_addr(addr), .i_global_write_n(ctl[1]),
    .i_byte_write_enable_n(ctl[0]), .i_byte_lane_write_n(lane_n), .i_output_enable_n(hoe_n),
    .i_data_io(wire_q[31:0]), .i_parity_io(wire_q[35:32]), .o_data_io(dq), .o_parity_io(par),
    .o_data_oe(oe), .o_wbuf_ready(rdy));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic idle(input logic oe_n);  // deselect, closes any burst
    i_host.bus(C_RD, S_OFF, 4'hF, 6'h0, 36'h0, oe_n);
  endtask
  task automatic wr(input logic [5:0] a, input logic [35:0] d);
    i_host.bus(C_WR, S_OK, 4'hF, a, d, 1'b1);
    mem[a] = d;
  endtask
  task automatic rdchk(input logic [5:0] a);
    i_host.bus(C_RD, S_OK, 4'hF, a, 36'h0, 1'b0);
    idle(1'b0);
    i_host.bus(C_CUR, S_OK, 4'hF, a, 36'h0, 1'b0);
    #1;
    chk("read data", {par, dq}, mem[a]);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_global;  // back to back global writes
    for (int a = 32; a < 36; a++) wr(6'(a), {4'(a), {4{2'(a), 6'(a)}}});
    repeat (4) idle(1'b1);
    for (int a = 32; a < 36; a++) rdchk(6'(a));
    chk("buffer ready", rdy, 1'b1);
  endtask
  task automatic t_lanes;  // every lane combination
    logic [35:0] nd;
    nd = 36'hF_5A3C_96E1;
    for (int m = 0; m < 16; m++) begin
      wr(6'h08, 36'h0_1234_5678);
      i_host.bus(C_BW, S_OK, 4'(m), 6'h08, nd, 1'b1);
      for (int l = 0; l < 4; l++) if (!m[l]) {mem[8][32+l], mem[8][8*l+:8]} = {nd[32+l], nd[8*l+:8]};
      repeat (4) idle(1'b1);
      rdchk(6'h08);
    end
    i_host.bus(C_RD, S_OK, 4'h0, 6'h08, nd, 1'b1);
    rdchk(6'h08);
  endtask
  task automatic t_proc;  // processor strobe start
    wr(6'h10, 36'hA_5A5A_5A5A);
    repeat (4) idle(1'b1);
    i_host.bus(C_PSW, S_OK, 4'h0, 6'h10, 36'h5_0000_0005, 1'b1);
    repeat (4) idle(1'b1);
    rdchk(6'h10);
    i_host.bus(C_PS, S_OK, 4'hF, 6'h10, 36'h0, 1'b1);
    i_host.bus(C_CUW, S_OK, 4'hF, 6'h10, 36'h3_C3C3_C3C3, 1'b1);
    mem[16] = 36'h3_C3C3_C3C3;
    repeat (4) idle(1'b1);
    rdchk(6'h10);
  endtask
  task automatic t_burst;  // both orders, every start, then suspend
    logic [1:0] j;
    for (int md = 0; md < 2; md++) for (int st = 0; st < 4; st++) begin
      idle(1'b0);
      mode <= md[0];
      for (int k = 0; k < 7; k++) begin
        i_host.bus(k == 0 ? C_RD : (k < 4 ? C_NXR : C_CUR), S_OK, 4'hF, 6'(32 + st), 36'h0, 1'b0);
        #1;
        j = (k > 5) ? 2'd3 : 2'(k - 2);
        if (k >= 2) chk("burst data", {par, dq}, mem[32 + (md ? (st ^ j) : ((st + j) & 3))]);
      end
    end
    i_host.bus(C_CUR, S_OK, 4'hF, 6'h20, 36'h0, 1'b1);
    #1;
    chk("drive off", oe, 1'b0);
    i_host.bus(C_CUR, S_OK, 4'hF, 6'h20, 36'h0, 1'b0);
    #1;
    chk("drive on", oe, 1'b1);
    en <= 1'b0;  // frozen: advances must not move the burst
    repeat (2) i_host.bus(C_NXR, S_OK, 4'hF, 6'h20, 36'h0, 1'b0);
    #1;
    chk("frozen", {oe, par, dq}, {1'b1, mem[32]});
    en <= 1'b1;
  endtask
  task automatic t_wburst;  // write burst, output enable left low
    idle(1'b1);
    mode <= 1'b0;
    wr(6'h28, 36'h1_1111_1111);
    i_host.bus(C_NXW, S_OK, 4'hF, 6'h28, 36'h2_2222_2222, 1'b0);
    i_host.bus(C_CUW, S_OK, 4'hF, 6'h28, 36'h3_3333_3333, 1'b0);
    i_host.bus(C_NXW, S_OK, 4'hF, 6'h28, 36'h4_4444_4444, 1'b0);
    mem[41] = 36'h3_3333_3333;
    mem[42] = 36'h4_4444_4444;
    repeat (4) idle(1'b1);
    for (int a = 40; a < 43; a++) rdchk(6'(a));
  endtask
  task automatic t_desel;  // each select made bad alone, plus a processor start
    logic [7:0] bad [4];
    bad = '{{C_RD, 3'h6}, {C_RD, 3'h0}, {C_RD, 3'h3}, {C_PS, 3'h0}};
    for (int i = 0; i < 4; i++) begin
      i_host.bus(C_RD, S_OK, 4'hF, 6'h20, 36'h0, 1'b0);
      i_host.bus(bad[i][7:3], bad[i][2:0], 4'hF, 6'h20, 36'h0, 1'b0);
      i_host.bus(C_CUR, S_OK, 4'hF, 6'h20, 36'h0, 1'b0);
      #1;
      chk("last read held", {oe, par, dq}, {1'b1, mem[32]});
      i_host.bus(C_CUR, S_OK, 4'hF, 6'h20, 36'h0, 1'b0);
      #1;
      chk("released", oe, 1'b0);
    end
  endtask
  task automatic t_sleep;  // reads offered while asleep
    idle(1'b1);
    i_host.nap(1'b1);
    for (int k = 0; k < 8; k++) begin
      i_host.bus(C_RD, k < 2 ? S_OFF : S_OK, 4'hF, 6'h20, 36'h0, 1'b0);
      #1;
      if (k >= 3) chk("sleep drive", oe, 1'b0);
    end
    idle(1'b1);
    i_host.nap(1'b0);
    repeat (3) i_host.bus(C_CUR, 3'h5, 4'hF, 6'h0, 36'h0, 1'b1);
    rdchk(6'h20);
  endtask

  // watchdog on a hang
  initial begin
    #(40 * 5000);
    n_fail++;
    stop_test;
  end
  // main sequence
  initial begin
    rstn = 1'b0;
    mode = 1'b0;
    en = 1'b1;
    n_fail = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk("reset state", {rdy, oe}, 2'b10);
    t_global;
    t_lanes;
    t_proc;
    t_burst;
    t_wburst;
    t_desel;
    t_sleep;
    stop_test;
  end
endmodule // test_pbs_sram_port
